/* wdt_cfg.svh */
// Constants for the default-start watchdog: register fields, keys, encodings.
// Assumes inclusion by the watchdog module and its testbench only.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ----------------------------------------------------------------------
// Mode register layout
// ----------------------------------------------------------------------
`define WDT_MODE_RESET_VAL    8'h67
`define WDT_MODE_STOP_VAL     8'h00
`define WDT_MODE_MD_HI        6
`define WDT_MODE_MD_LO        5
`define WDT_CLKSEL_HI         4
`define WDT_CLKSEL_LO         0
`define WDT_MD_STOP           2'h0
`define WDT_MD_NMI            2'h1
`define WDT_CLKSEL_RESET      5'h07

// ----------------------------------------------------------------------
// Trigger register keys
// ----------------------------------------------------------------------
`define WDT_CLEAR_KEY         8'hAC
`define WDT_TRIGGER_READ_VAL  8'h9A

// ----------------------------------------------------------------------
// Clock-select source groups (bits 4:3 of the select field)
// ----------------------------------------------------------------------
`define WDT_SRC_INTOSC        2'h0
`define WDT_SRC_MAIN          2'h1
`define WDT_SRC_SUB           2'h2
`define WDT_DIV_BASE          13
`define WDT_RST_HOLD_CYCLES   4'h2

`endif

/* wdt_pkg.sv */
// Types shared by the watchdog design.
// Assumes wdt_cfg.svh is on the include path.
package wdt_pkg;
  typedef enum logic [2:0]
  {
    ST_RUN   = 3'b001,
    ST_OVF   = 3'b010,
    ST_RESET = 3'b100
  } wdt_state_type;
endpackage

/* default_start_watchdog.sv */
// Default-start watchdog: counter, mode and trigger registers, overflow.
// Assumes the CPU write/read strobes are on core_clk_in; oscillator
// ticks and the oscillator run level come from other domains.
//
// Functional notes
// - Counting starts by itself in reset mode once reset is released.
// - Default is reset mode, interval internal oscillator over 2^19.
// - A second mode write forces overflow and clears the counter.
// - A trigger write other than the clear key forces overflow.
// - With the watchdog stopped, none of the three fault writes (second mode write, bad key, bit operation) forces overflow.
// - Stopping the internal oscillator halts counting when it is selected.
// - Outside reset mode an overflow raises a non-maskable request.
// - A five-bit select field chooses the count clock and rate.
// - Trigger register reads always return the fixed read value.
// - A single-bit manipulation of the trigger register forces overflow.
`timescale 1ns/10ps
`include "wdt_cfg.svh"

module default_start_watchdog
#(
  parameter int CNT_W = 24
)
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       intosc_tick_in,
  input  wire logic       main_tick_in,
  input  wire logic       sub_tick_in,
  input  wire logic       intosc_run_in,
  input  wire logic       mode_wr_in,
  input  wire logic       trig_wr_in,
  input  wire logic       trig_bitop_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       mode_rd_in,
  input  wire logic       trig_rd_in,
  output logic      [7:0] rdata_out,
  output logic            watchdog_nmi_request_out,
  output logic            sys_reset_req_out,
  output logic            running_out
);

  // --------------------------------------------------------------------
  // Synchronisers for the foreign-domain inputs
  // --------------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [2:0] sync3_q;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {intosc_run_in, sub_tick_in, main_tick_in, intosc_tick_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q[2:0];
    end
  end

  // Ticks are level toggles from slow clocks; only a rising edge counts, so two toggles make one count.
  logic [2:0] tick_edge;
  logic       osc_run;
  assign tick_edge = sync2_q[2:0] & ~sync3_q[2:0];
  assign osc_run   = sync2_q[3];

  // --------------------------------------------------------------------
  // Mode register and write tracking
  // --------------------------------------------------------------------
  wdt_pkg::wdt_state_type state_q;
  logic [7:0]             mode_q;
  logic                   mode_written_q;
  logic [1:0]             md;
  logic [4:0]             clksel;
  logic                   stopped;
  logic                   force_ovf;
  logic                   clear_cnt;
  logic                   ovf;

  assign md      = mode_q[`WDT_MODE_MD_HI:`WDT_MODE_MD_LO];
  assign clksel  = mode_q[`WDT_CLKSEL_HI:`WDT_CLKSEL_LO];
  assign stopped = (md == `WDT_MD_STOP) && (mode_q != `WDT_MODE_RESET_VAL);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_q         <= `WDT_MODE_RESET_VAL;
      mode_written_q <= 1'b0;
    end
    else if (state_q == wdt_pkg::ST_RESET)
    begin
      mode_q         <= `WDT_MODE_RESET_VAL;
      mode_written_q <= 1'b0;
    end
    else if (mode_wr_in && !mode_written_q)
    begin
      mode_q         <= wdata_in;
      mode_written_q <= 1'b1;
    end
  end

  // Mode bits 00 mean stop with any select; the reset value carries mode
  // bits 11, so it is reset mode, as is 10; 01 is interrupt mode.
  logic reset_mode;
  assign reset_mode = !stopped && (md != `WDT_MD_NMI);

  // Second mode write, bad key, or bit operation on trigger.
  assign force_ovf = !stopped &&
    ((mode_wr_in && mode_written_q) ||
     (trig_wr_in && wdata_in != `WDT_CLEAR_KEY) ||
     trig_bitop_in);
  assign clear_cnt = (trig_wr_in && !trig_bitop_in &&
                      wdata_in == `WDT_CLEAR_KEY) ||
                     (mode_wr_in && mode_written_q);

  // --------------------------------------------------------------------
  // Counter and clock selection
  // --------------------------------------------------------------------
  logic             cnt_tick;
  logic [CNT_W-1:0] cnt_q;
  logic [4:0]       shift;
  logic             at_limit;

  always_comb
  begin
    case (clksel[4:3])
      `WDT_SRC_INTOSC: cnt_tick = tick_edge[0] && osc_run;
      `WDT_SRC_MAIN:   cnt_tick = tick_edge[1];
      `WDT_SRC_SUB:    cnt_tick = tick_edge[2];
      default:         cnt_tick = tick_edge[0] && osc_run;
    endcase
  end

  logic [CNT_W-1:0] limit;

  // Interval is 2^(base+select-1) ticks; the default select 7 gives 2^19.
  assign shift    = 5'(`WDT_DIV_BASE) + {2'h0, clksel[2:0]} - 5'h1;
  assign limit    = (CNT_W'(1) << shift) - CNT_W'(1);
  assign at_limit = cnt_tick && (cnt_q == limit);
  assign ovf      = !stopped && (at_limit || force_ovf);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_q <= '0;
    else if (state_q != wdt_pkg::ST_RUN || clear_cnt || ovf)
      cnt_q <= '0;
    else if (!stopped && cnt_tick)
      cnt_q <= cnt_q + CNT_W'(1);
  end

  // --------------------------------------------------------------------
  // Overflow handling
  // --------------------------------------------------------------------
  logic [3:0] hold_q;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= wdt_pkg::ST_RUN;
      hold_q  <= 4'h0;
    end
    else
    begin
      case (state_q)
        wdt_pkg::ST_RUN:
        begin
          hold_q <= 4'h0;
          if (ovf && reset_mode)
            state_q <= wdt_pkg::ST_RESET;
          else if (ovf)
            state_q <= wdt_pkg::ST_OVF;
        end
        wdt_pkg::ST_OVF:
          state_q <= wdt_pkg::ST_RUN;
        wdt_pkg::ST_RESET:
        begin
          hold_q <= hold_q + 4'h1;
          if (hold_q == `WDT_RST_HOLD_CYCLES - 4'h1)
            state_q <= wdt_pkg::ST_RUN;
        end
        default:
          state_q <= wdt_pkg::ST_RUN;
      endcase
    end
  end

  assign watchdog_nmi_request_out = (state_q == wdt_pkg::ST_OVF);
  assign sys_reset_req_out        = (state_q == wdt_pkg::ST_RESET);
  assign running_out              = !stopped && state_q == wdt_pkg::ST_RUN;

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (trig_rd_in)
      rdata_out <= `WDT_TRIGGER_READ_VAL;
    else if (mode_rd_in)
      rdata_out <= mode_q;
    else
      rdata_out <= 8'h00;
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_second_mode_write: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (mode_wr_in && mode_written_q && !stopped && state_q == wdt_pkg::ST_RUN)
    |=> (sys_reset_req_out || watchdog_nmi_request_out))
    else $error("second mode write did not overflow");
  a_bad_key_ovf: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (trig_wr_in && wdata_in != `WDT_CLEAR_KEY && !stopped &&
     state_q == wdt_pkg::ST_RUN)
    |=> (sys_reset_req_out || watchdog_nmi_request_out))
    else $error("bad key did not overflow");
  a_stop_no_ovf: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (stopped && state_q == wdt_pkg::ST_RUN)
    |=> !sys_reset_req_out && !watchdog_nmi_request_out)
    else $error("stopped watchdog overflowed");
  a_bitop_ovf: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (trig_bitop_in && !stopped && state_q == wdt_pkg::ST_RUN)
    |=> (sys_reset_req_out || watchdog_nmi_request_out))
    else $error("bit operation did not overflow");
  a_good_key_clear: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (trig_wr_in && !trig_bitop_in && wdata_in == `WDT_CLEAR_KEY &&
     !(mode_wr_in && mode_written_q) && state_q == wdt_pkg::ST_RUN)
    |=> cnt_q == '0 && !sys_reset_req_out && !watchdog_nmi_request_out)
    else $error("clear key misbehaved");
  a_trig_read: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    trig_rd_in |=> rdata_out == `WDT_TRIGGER_READ_VAL)
    else $error("trigger read value wrong");
  a_reset_pulse: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    $rose(sys_reset_req_out) |-> sys_reset_req_out[*2] ##1
    (!sys_reset_req_out && mode_q == `WDT_MODE_RESET_VAL))
    else $error("reset request length or default wrong");
  a_nmi_mode: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    watchdog_nmi_request_out |-> $past(md) == `WDT_MD_NMI ##1
    !watchdog_nmi_request_out)
    else $error("nmi outside nmi mode");
  a_osc_halt: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    (!osc_run && clksel[4:3] == `WDT_SRC_INTOSC && !clear_cnt &&
     state_q == wdt_pkg::ST_RUN && !ovf) |=> $stable(cnt_q))
    else $error("counter moved with oscillator stopped");

  c_reset_ovf: cover property (@(posedge core_clk_in) $rose(sys_reset_req_out));
  c_nmi: cover property (@(posedge core_clk_in) watchdog_nmi_request_out);
  c_clear: cover property (@(posedge core_clk_in)
    trig_wr_in && wdata_in == `WDT_CLEAR_KEY);
  c_stop: cover property (@(posedge core_clk_in) stopped);

endmodule // default_start_watchdog

/* test_default_start_watchdog.sv */
// Self-checking testbench for the default-start watchdog.
// Assumes wdt_cfg.svh on the include path and the design files compiled.
`timescale 1ns/10ps
`include "wdt_cfg.svh"

module test_default_start_watchdog;
  typedef struct {int cyc; logic [10:0] val; logic [10:0] msk;} note_type;
  logic       core_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       intosc_tick_in = 1'b0;
  logic       main_tick_in = 1'b0;
  logic       sub_tick_in = 1'b0;
  logic       intosc_run_in = 1'b1;
  logic [4:0] strb = 5'h00;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] rdata_out;
  logic       nmi_out;
  logic       sreq_out;
  logic       running_out;
  int         cyc = 0;
  int         failures = 0;
  int         n_tests = 0;
  int         nmi_count = 0;
  int         base;
  logic [7:0] k;
  note_type   q[$];

  default_start_watchdog i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .intosc_tick_in(intosc_tick_in), .main_tick_in(main_tick_in),
    .sub_tick_in(sub_tick_in), .intosc_run_in(intosc_run_in),
    .mode_wr_in(strb[0]), .trig_wr_in(strb[1]), .trig_bitop_in(strb[2]),
    .wdata_in(wdata_in), .mode_rd_in(strb[3]), .trig_rd_in(strb[4]),
    .rdata_out(rdata_out), .watchdog_nmi_request_out(nmi_out),
    .sys_reset_req_out(sreq_out), .running_out(running_out));

  initial forever #2.5 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      failures++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // The watcher compares each note when its cycle comes round.
  initial forever
  begin
    @(posedge core_clk_in);
    #2;
    if (nmi_out === 1'b1)
      nmi_count++;
    while (q.size() > 0 && q[0].cyc <= cyc)
    begin
      check({rdata_out, nmi_out, sreq_out, running_out} & q[0].msk,
            q[0].val & q[0].msk);
      void'(q.pop_front());
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------------
  function automatic logic [10:0] w(logic [7:0] rd, logic n, logic s);
    return {rd, n, s, 1'b0};
  endfunction

  // One strobe, then three notes for the cycles after the taking edge.
  task automatic op(input int kind, input logic [7:0] d,
                    input logic [10:0] v1, v2, v3);
    strb = 5'h01 << kind;
    wdata_in = d;
    q.push_back('{cyc + 1, v1, 11'h7FE});
    q.push_back('{cyc + 2, v2, 11'h7FE});
    q.push_back('{cyc + 3, v3, 11'h7FE});
    @(posedge core_clk_in);
    #1;
    strb = 5'h00;
    repeat (3) @(posedge core_clk_in);
    #1;
  endtask

  task automatic run_is(input logic r);
    q.push_back('{cyc, {10'h000, r}, 11'h001});
    @(posedge core_clk_in);
    #1;
  endtask

  // Main and sub ticks run faster, so a wrong source would overflow early.
  task automatic ticks(input int n);
    repeat (2 * n)
    begin
      intosc_tick_in = ~intosc_tick_in;
      repeat (2)
      begin
        @(posedge core_clk_in);
        #1;
        main_tick_in = ~main_tick_in;
        sub_tick_in = ~sub_tick_in;
      end
    end
  endtask

  task automatic do_reset();
    rst_in = 1'b1;
    repeat (6) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
  endtask

  function automatic logic [7:0] bad_key();
    logic [7:0] r;
    r = 8'($urandom());
    return (r == `WDT_CLEAR_KEY) ? 8'h53 : r;
  endfunction

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(90814));
    do_reset();
    run_is(1'b1);
    op(3, 8'h00, w(`WDT_MODE_RESET_VAL, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(4, 8'h00, w(`WDT_TRIGGER_READ_VAL, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(1, bad_key(), w(0, 0, 1), w(0, 0, 1), w(0, 0, 0));
    op(3, 8'h00, w(`WDT_MODE_RESET_VAL, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(1, `WDT_CLEAR_KEY, w(0, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(4, 8'h00, w(`WDT_TRIGGER_READ_VAL, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(0, 8'h20, w(0, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(3, 8'h00, w(8'h20, 0, 0), w(0, 0, 0), w(0, 0, 0));
    base = nmi_count;
    ticks(2048);
    intosc_run_in = 1'b0;
    ticks(1024);
    intosc_run_in = 1'b1;
    ticks(2047);
    repeat (8) @(posedge core_clk_in);
    #1;
    check(11'(nmi_count - base), 11'h000);
    ticks(1);
    repeat (8) @(posedge core_clk_in);
    #1;
    check(11'(nmi_count - base), 11'h001);
    // Half an interval first, so a counter left uncleared would overflow.
    ticks(2048);
    op(0, 8'($urandom()), w(0, 1, 0), w(0, 0, 0), w(0, 0, 0));
    base = nmi_count;
    ticks(4095);
    repeat (8) @(posedge core_clk_in);
    #1;
    check(11'(nmi_count - base), 11'h000);
    op(1, bad_key(), w(0, 1, 0), w(0, 0, 0), w(0, 0, 0));
    op(2, 8'h00, w(0, 1, 0), w(0, 0, 0), w(0, 0, 0));
    do_reset();
    op(1, `WDT_CLEAR_KEY, w(0, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(0, `WDT_MODE_STOP_VAL, w(0, 0, 0), w(0, 0, 0), w(0, 0, 0));
    run_is(1'b0);
    op(0, 8'($urandom()), w(0, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(1, bad_key(), w(0, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(2, 8'h00, w(0, 0, 0), w(0, 0, 0), w(0, 0, 0));
    op(3, 8'h00, w(`WDT_MODE_STOP_VAL, 0, 0), w(0, 0, 0), w(0, 0, 0));
    // Main clock, then subclock, as count source in interrupt mode.
    k = 8'h28;
    repeat (2)
    begin
      do_reset();
      op(0, k, w(0, 0, 0), w(0, 0, 0), w(0, 0, 0));
      base = nmi_count;
      ticks(2047);
      repeat (8) @(posedge core_clk_in);
      #1;
      check(11'(nmi_count - base), 11'h000);
      ticks(1);
      repeat (8) @(posedge core_clk_in);
      #1;
      check(11'(nmi_count - base), 11'h001);
      k = 8'h30;
    end
    repeat (4) @(posedge core_clk_in);
    complete_run();
  end
endmodule // test_default_start_watchdog
